// ==== rtl/sgd_current_sel.sv ====
/*
 maps a gate current setting onto the drive level; the hardware variant's
 seven-level pin code is spread over the same sixteen-step range.
*/
`include "sgd_map.svh"
module sgd_current_sel
(
    // setting
    input wire logic hwVariant,
    input wire logic [3:0] regLevel,
    input wire logic [2:0] pinLevel,
    // result
    output logic [3:0] level
);
    function automatic logic [3:0] spreadPin(input logic [2:0] code);
        logic [2:0] c;
        c = (code > 3'h6) ? 3'h6 : code;
        // seven levels 2.5 apart mapped onto 0..15, ends kept exact
        spreadPin = (c == 3'h6) ? 4'hf : 4'({c, 1'b0} + {1'b0, c[2:1]});
    endfunction : spreadPin

    always_comb
    begin
        level = hwVariant ? spreadPin(pinLevel) : regLevel;
    end
endmodule : sgd_current_sel

// ==== rtl/sgd_fault_latch.sv ====
/*
 sticky fault flags with an active-low indicator; set wins over clear.
*/
module sgd_fault_latch
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // events
    input wire logic gateFaultEv,
    input wire logic uvEv,
    input wire logic clearFault,
    // status
    output logic gateFault,
    output logic supplyUv,
    output logic fault_indicator_n
);
    logic next_gateFault;
    logic next_supplyUv;
    always_comb
    begin
        next_gateFault = gateFaultEv | (gateFault & ~clearFault);
        next_supplyUv = uvEv | (supplyUv & ~clearFault);
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            gateFault <= 1'b0;
            supplyUv <= 1'b0;
            fault_indicator_n <= 1'b1;
        end
        else
        begin
            gateFault <= next_gateFault;
            supplyUv <= next_supplyUv;
            fault_indicator_n <= ~(next_gateFault | next_supplyUv);
        end
    end
endmodule : sgd_fault_latch

// ==== rtl/sgd_half_bridge.sv ====
/*
 one half-bridge gate-drive sequencer: monitored dead time, optional digital
 dead time, drive window with strong opposite pulldown, hold current after,
 gate fault check and supply undervoltage flags. assumes the gate-source
 comparators and supply monitors are already synchronous to clk_sys.
*/
`include "sgd_map.svh"

// Notes on behaviour
// RQ1 - incoming gate turns on only once outgoing gate-source monitor shows off
// RQ2 - optional digital dead time added after the monitored handshake
// RQ3 - high-to-low with current into bridge waits extra detector discharge
// RQ4 - strong pulldown on opposite gate for the whole drive window
// RQ5 - selected current during drive window, hold current afterwards
// RQ6 - 16 register levels or 7 pin levels over the same range
// RQ7 - gate fault if gate voltage misses threshold when window ends
// RQ8 - one gate-source monitor each for high and low side
// RQ9 - drive window never stretches PWM; new command ends it at once
// RQ10 - controller sets the window longer than the gate charge time
// RQ11 - pump and low-side supply watched for undervoltage continuously
// RQ12 - independent mode: each gate follows its input, no handshake
// RQ13 - gate fault or undervoltage latched and shown on fault_indicator_n
module sgd_half_bridge #(
    parameter int DRIVE_W = 12,
    parameter int DEAD_W = 8
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pwm commands
    input wire logic pwmHigh,
    input wire logic pwmLow,
    input wire logic [1:0] pwmMode,
    // configuration
    input wire logic [DRIVE_W-1:0] gate_drive_timer,
    input wire logic [DEAD_W-1:0] deadCycles,
    input wire logic hwVariant,
    input wire logic [3:0] gate_current_select,
    input wire logic [2:0] currentPin,
    input wire logic clearFault,
    // gate-source monitors and supplies
    input wire logic vgsHighOn,
    input wire logic vgsLowOn,
    input wire logic phaseCurrentIn,
    input wire logic high_side_pump_supply_ok,
    input wire logic low_side_gate_supply_ok,
    // gate drive
    output logic high_gate_out,
    output logic low_gate_out,
    output logic highStrongPd,
    output logic lowStrongPd,
    output logic [3:0] gateCurrent,
    // status
    output logic gateFault,
    output logic supplyUv,
    output logic fault_indicator_n
);
    localparam logic [7:0] DISCH = 8'(`SGD_DISCHARGE_CYC);

    sgd_pkg::sgd_state_e state, next_state;
    logic [1:0] target, next_target;     // {high, low} commanded
    logic [1:0] gates, next_gates;
    logic [DRIVE_W-1:0] timer, next_timer;
    logic [DEAD_W-1:0] dead, next_dead;
    logic [7:0] disch, next_disch;
    logic lastOn, next_lastOn;           // 1 = latest new command has the high gate on
    logic pdHigh, next_pdHigh;
    logic pdLow, next_pdLow;
    logic [3:0] cur, next_cur;
    logic gateFaultEv;
    logic [3:0] selLevel;
    logic [1:0] cmd;
    logic indep;
    logic newCmd;

    sgd_current_sel u_sel
    (
        .hwVariant(hwVariant),
        .regLevel(gate_current_select),
        .pinLevel(currentPin),
        .level(selLevel)
    ); // [RQ6]

    sgd_fault_latch u_flt
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .gateFaultEv(gateFaultEv),
        .uvEv(~high_side_pump_supply_ok | ~low_side_gate_supply_ok), // [RQ11]
        .clearFault(clearFault),
        .gateFault(gateFault),
        .supplyUv(supplyUv),
        .fault_indicator_n(fault_indicator_n)
    ); // [RQ13]

    // a command asking for both gates in handshake mode is taken as both off
    always_comb
    begin
        indep = (pwmMode == `SGD_MODE_INDEP);
        cmd = {pwmHigh, pwmLow};
        if (!indep && pwmHigh && pwmLow)
            cmd = 2'b00;
        newCmd = (cmd != target);
    end

    always_comb
    begin
        next_state = state;
        next_target = cmd;
        next_gates = gates;
        next_timer = timer;
        next_dead = dead;
        next_disch = disch;
        next_lastOn = lastOn;
        next_pdHigh = 1'b0;
        next_pdLow = 1'b0;
        next_cur = `SGD_CUR_HOLD;
        gateFaultEv = 1'b0;
        if (indep)
        begin
            next_gates = cmd; // [RQ12]
            next_state = sgd_pkg::SGD_IDLE;
        end
        else if (newCmd)
        begin
            // a new command ends any window at once [RQ9]
            next_gates = gates & cmd;      // turn-offs act immediately
            next_lastOn = cmd[1];
            next_dead = deadCycles;
            next_disch = (gates[1] && cmd[0] && phaseCurrentIn) ? DISCH : 8'h0;
            next_timer = gate_drive_timer;
            next_state = (cmd == 2'b00 || (gates & cmd) == cmd) ?
                sgd_pkg::SGD_DRIVE : sgd_pkg::SGD_WAIT_OFF;
            next_cur = selLevel; // [RQ5]
            // keep the opposite pulldown from the first switching cycle on
            next_pdHigh = ~cmd[1]; // [RQ4]
            next_pdLow = ~cmd[0];
        end
        else
        begin
            unique case (state)
                sgd_pkg::SGD_IDLE:
                    next_state = state;
                sgd_pkg::SGD_WAIT_OFF:
                begin
                    next_cur = selLevel;
                    next_pdHigh = ~target[1];
                    next_pdLow = ~target[0];
                    // incoming waits for outgoing gate-source off [RQ1] [RQ8]
                    if ((target[0] && !vgsHighOn) || (target[1] && !vgsLowOn))
                        next_state = sgd_pkg::SGD_DISCHARGE;
                end
                sgd_pkg::SGD_DISCHARGE:
                begin
                    next_cur = selLevel;
                    next_pdHigh = ~target[1]; // [RQ4]
                    next_pdLow = ~target[0];
                    if (disch == 8'h0)
                        next_state = sgd_pkg::SGD_DEAD;
                    else
                        next_disch = disch - 8'h1; // [RQ3]
                end
                sgd_pkg::SGD_DEAD:
                begin
                    next_cur = selLevel;
                    next_pdHigh = ~target[1]; // [RQ4]
                    next_pdLow = ~target[0];
                    if (dead == '0)
                    begin
                        next_gates = target;
                        next_timer = gate_drive_timer;
                        next_state = sgd_pkg::SGD_DRIVE;
                    end
                    else
                        next_dead = dead - 1'b1; // [RQ2]
                end
                sgd_pkg::SGD_DRIVE:
                begin
                    next_cur = selLevel; // [RQ5]
                    next_pdHigh = ~target[1]; // [RQ4]
                    next_pdLow = ~target[0];
                    if (timer <= DRIVE_W'(1))
                    begin
                        next_cur = `SGD_CUR_HOLD;
                        next_pdHigh = 1'b0;
                        next_pdLow = 1'b0;
                        next_state = sgd_pkg::SGD_IDLE;
                        // gate must match its command at window end [RQ7]
                        gateFaultEv = (vgsHighOn != target[1]) ||
                            (vgsLowOn != target[0]);
                    end
                    else
                        next_timer = timer - 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= sgd_pkg::SGD_IDLE;
            target <= 2'b00;
            gates <= 2'b00;
            timer <= '0;
            dead <= '0;
            disch <= 8'h0;
            lastOn <= 1'b0;
            pdHigh <= 1'b0;
            pdLow <= 1'b0;
            cur <= `SGD_CUR_HOLD;
        end
        else
        begin
            state <= next_state;
            target <= next_target;
            gates <= next_gates;
            timer <= next_timer;
            dead <= next_dead;
            disch <= next_disch;
            lastOn <= next_lastOn;
            pdHigh <= next_pdHigh;
            pdLow <= next_pdLow;
            cur <= next_cur;
        end
    end

    always_comb
    begin
        high_gate_out = gates[1];
        low_gate_out = gates[0];
        highStrongPd = pdHigh;
        lowStrongPd = pdLow;
        gateCurrent = cur;
    end

    no_shoot_a: assert property (@(posedge clk_sys) disable iff (rst)
        !indep |-> !(high_gate_out && low_gate_out))
        else $error("both gates on in handshake mode"); // [RQ1]
    low_waits_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!indep && $rose(low_gate_out)) |-> !$past(vgsHighOn) ||
        $past(state) == sgd_pkg::SGD_DEAD)
        else $error("low gate on while high still on"); // [RQ1]
    indep_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
        indep |=> (high_gate_out == $past(pwmHigh)) &&
        (low_gate_out == $past(pwmLow)))
        else $error("independent gate not following input"); // [RQ12]
    pd_opposite_a: assert property (@(posedge clk_sys) disable iff (rst)
        highStrongPd |-> !high_gate_out)
        else $error("pulldown on a driven gate"); // [RQ4]
    hold_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state == sgd_pkg::SGD_IDLE && $past(state) == sgd_pkg::SGD_IDLE)
        |-> gateCurrent == `SGD_CUR_HOLD)
        else $error("hold current not used after window"); // [RQ5]
    window_cut_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!indep && newCmd && state == sgd_pkg::SGD_DRIVE) |=>
        timer == $past(gate_drive_timer))
        else $error("new command did not restart window"); // [RQ9]
    uv_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        !high_side_pump_supply_ok |=> supplyUv && !fault_indicator_n)
        else $error("pump undervoltage not flagged"); // [RQ11]
    fault_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        gateFaultEv |=> gateFault && !fault_indicator_n)
        else $error("gate fault not latched"); // [RQ7]
    disch_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state == sgd_pkg::SGD_DISCHARGE && disch != 8'h0 && !newCmd) |=>
        state == sgd_pkg::SGD_DISCHARGE)
        else $error("discharge delay skipped"); // [RQ3]
    pd_low_a: assert property (@(posedge clk_sys) disable iff (rst)
        lowStrongPd |-> !low_gate_out)
        else $error("pulldown on a driven low gate"); // [RQ4]
    high_after_dead_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!indep && !$past(indep) && $rose(high_gate_out)) |->
        $past(state) == sgd_pkg::SGD_DEAD)
        else $error("high gate on without handshake"); // [RQ1]
    dead_count_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!indep && !newCmd && state == sgd_pkg::SGD_DEAD && dead != '0) |=>
        state == sgd_pkg::SGD_DEAD)
        else $error("digital dead time cut short"); // [RQ2]
    wait_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!indep && !newCmd && state == sgd_pkg::SGD_WAIT_OFF && target[0] &&
        vgsHighOn) |=> !low_gate_out)
        else $error("low gate on before high monitor off"); // [RQ1]
    cur_window_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!indep && !newCmd && state == sgd_pkg::SGD_DRIVE &&
        timer > DRIVE_W'(1)) |=> gateCurrent == $past(selLevel))
        else $error("selected current missing in window"); // [RQ5]
    pd_window_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!indep && !newCmd && state == sgd_pkg::SGD_DRIVE &&
        timer > DRIVE_W'(1) && !target[1]) |=> highStrongPd)
        else $error("pulldown missing in window"); // [RQ4]
    uv_low_a: assert property (@(posedge clk_sys) disable iff (rst)
        !low_side_gate_supply_ok |=> supplyUv)
        else $error("low-side supply undervoltage not flagged"); // [RQ11]
    flt_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (clearFault && !gateFaultEv) |=> !gateFault)
        else $error("gate fault not cleared"); // [RQ13]
    indicator_a: assert property (@(posedge clk_sys) disable iff (rst)
        (gateFault || supplyUv) |-> !fault_indicator_n)
        else $error("fault indicator high with a flag set"); // [RQ13]
endmodule : sgd_half_bridge

// ==== rtl/sgd_map.svh ====
/*
 holds the timing counts, field widths and reset values of the gate-drive
 sequencer as macros; assumes a 40 MHz clk_sys.
*/
`ifndef SGD_MAP_SVH
`define SGD_MAP_SVH
`define SGD_CLK_NS 25
`define SGD_DISCHARGE_NS 200
`define SGD_DISCHARGE_CYC ((`SGD_DISCHARGE_NS + `SGD_CLK_NS - 1) / `SGD_CLK_NS)
`define SGD_CUR_W 4
`define SGD_HW_LEVELS 7
`define SGD_SPI_LEVELS 16
`define SGD_CUR_HOLD 4'h0
`define SGD_MODE_INDEP 2'h3
`endif

// ==== rtl/sgd_pkg.sv ====
/*
 holds the types of the gate-drive sequencer; no assumptions.
*/
package sgd_pkg;
    typedef enum logic [2:0] {
        SGD_IDLE,
        SGD_WAIT_OFF,
        SGD_DISCHARGE,
        SGD_DEAD,
        SGD_DRIVE
    } sgd_state_e;
endpackage : sgd_pkg

// ==== sim/sgd_gate_model.sv ====
/*
 external mosfet gates: each gate-source monitor follows its gate after a
 charge delay. assumes gate commands registered on clk_sys.
*/
module sgd_gate_model #(
    parameter int DLY = 3
)
(
    // clock
    input wire logic clk_sys,
    // gates and injected faults
    input wire logic hiGate,
    input wire logic loGate,
    input wire logic loStuck,
    // monitors
    output logic vgsHi,
    output logic vgsLo
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DLY-1:0] hiPipe = '0;
    logic [DLY-1:0] loPipe = '0;
    always @(posedge clk_sys)
    begin
        hiPipe <= {hiPipe[DLY-2:0], hiGate};
        loPipe <= {loPipe[DLY-2:0], loGate};
    end
    // a stuck gate never reaches threshold, so a fault must follow
    assign vgsHi = hiPipe[DLY-1];
    assign vgsLo = loPipe[DLY-1] & ~loStuck;
endmodule : sgd_gate_model

// ==== sim/test_smart_gate_drive_sequencer.sv ====
/*
 self-checking bench for one half-bridge sequencer with a gate model.
 assumes the design answers as its hand-over timing describes.
*/
module test_smart_gate_drive_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic pwmHigh = 1'b0, pwmLow = 1'b0, hwVariant = 1'b0;
    logic [1:0] pwmMode = 2'h0;
    logic [11:0] gate_drive_timer = 12'h00a;
    logic [7:0] deadCycles = 8'h00;
    logic [3:0] gate_current_select = 4'h9;
    logic [2:0] currentPin = 3'h0;
    logic clearFault = 1'b0, phaseCurrentIn = 1'b0, loStuck = 1'b0;
    logic high_side_pump_supply_ok = 1'b1, low_side_gate_supply_ok = 1'b1;
    logic vgsHighOn, vgsLowOn, high_gate_out, low_gate_out;
    logic highStrongPd, lowStrongPd, gateFault, supplyUv, fault_indicator_n;
    logic [3:0] gateCurrent;
    int miscompares = 0;
    int totalChecks = 0;
    int t0, t1, c;

    always #12.5 clk_sys = ~clk_sys;

    sgd_half_bridge #(.DRIVE_W(12), .DEAD_W(8)) i_sgd_half_bridge (
        .clk_sys(clk_sys), .rst(rst), .pwmHigh(pwmHigh), .pwmLow(pwmLow),
        .pwmMode(pwmMode), .gate_drive_timer(gate_drive_timer),
        .deadCycles(deadCycles), .hwVariant(hwVariant),
        .gate_current_select(gate_current_select), .currentPin(currentPin),
        .clearFault(clearFault), .vgsHighOn(vgsHighOn), .vgsLowOn(vgsLowOn),
        .phaseCurrentIn(phaseCurrentIn),
        .high_side_pump_supply_ok(high_side_pump_supply_ok),
        .low_side_gate_supply_ok(low_side_gate_supply_ok),
        .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
        .highStrongPd(highStrongPd), .lowStrongPd(lowStrongPd),
        .gateCurrent(gateCurrent), .gateFault(gateFault),
        .supplyUv(supplyUv), .fault_indicator_n(fault_indicator_n));

    sgd_gate_model #(.DLY(3)) i_sgd_gate_model (
        .clk_sys(clk_sys), .hiGate(high_gate_out), .loGate(low_gate_out),
        .loStuck(loStuck), .vgsHi(vgsHighOn), .vgsLo(vgsLowOn));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : tick

    task automatic waitGate(input logic hi, output int cyc);
        cyc = 0;
        while (((hi ? high_gate_out : low_gate_out) !== 1'b1) && cyc < 300)
        begin
            tick(1);
            cyc++;
        end
    endtask : waitGate

    // high side on, then hand over to low side and time the handover
    task automatic toLow(output int cyc);
        int w;
        pwmHigh = 1'b1;
        waitGate(1'b1, w);
        check(16'(lowStrongPd), 16'h1);
        tick(20);
        pwmHigh = 1'b0;
        pwmLow = 1'b1;
        waitGate(1'b0, cyc);
        check(16'(vgsHighOn), 16'h0);
        check(16'(highStrongPd), 16'h1);
        check(16'(lowStrongPd), 16'h0);
        check(16'(gateCurrent), 16'h9);
    endtask : toLow

    task automatic endOfTest();
        $display("checks %0d miscompares %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : endOfTest

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        endOfTest();
    end

    initial
    begin
        tick(8);
        rst = 1'b0;
        check(16'({high_gate_out, low_gate_out, gateCurrent}), 16'h0);
        check(16'({supplyUv, gateFault, fault_indicator_n}), 16'h1);
        toLow(t0);
        tick(14);
        check(16'({gateCurrent, highStrongPd}), 16'h0);
        check(16'(gateFault), 16'h0);
        pwmLow = 1'b0;
        tick(20);
        deadCycles = 8'h05;
        toLow(t1);
        check(16'(t1 - t0), 16'h5);
        pwmLow = 1'b0;
        deadCycles = 8'h00;
        phaseCurrentIn = 1'b1;
        tick(20);
        toLow(t1);
        check(16'(t1 - t0), 16'h8);
        pwmLow = 1'b0;
        phaseCurrentIn = 1'b0;
        tick(20);
        hwVariant = 1'b1;
        for (int p = 0; p < 7; p++)
        begin
            currentPin = 3'(p);
            pwmHigh = 1'b1;
            waitGate(1'b1, c);
            check(16'(gateCurrent), 16'(p * 2 + p / 2));
            pwmHigh = 1'b0;
            tick(20);
        end
        hwVariant = 1'b0;
        // a new command cuts the window short instead of waiting it out
        pwmLow = 1'b1;
        waitGate(1'b0, c);
        tick(2);
        pwmLow = 1'b0;
        pwmHigh = 1'b1;
        tick(1);
        check(16'(low_gate_out), 16'h0);
        waitGate(1'b1, c);
        check(16'(gateCurrent), 16'h9);
        tick(14);
        check(16'(gateFault), 16'h0);
        pwmHigh = 1'b0;
        tick(20);
        loStuck = 1'b1;
        pwmLow = 1'b1;
        waitGate(1'b0, c);
        tick(14);
        check(16'({gateFault, fault_indicator_n}), 16'h2);
        pwmLow = 1'b0;
        loStuck = 1'b0;
        tick(20);
        clearFault = 1'b1;
        tick(1);
        clearFault = 1'b0;
        tick(2);
        check(16'({gateFault, fault_indicator_n}), 16'h1);
        for (int i = 0; i < 2; i++)
        begin
            high_side_pump_supply_ok = (i != 0);
            low_side_gate_supply_ok = (i == 0);
            tick(3);
            check(16'({supplyUv, fault_indicator_n}), 16'h2);
            high_side_pump_supply_ok = 1'b1;
            low_side_gate_supply_ok = 1'b1;
            clearFault = 1'b1;
            tick(1);
            clearFault = 1'b0;
            tick(2);
            check(16'({supplyUv, fault_indicator_n}), 16'h1);
        end
        pwmMode = 2'h3;
        pwmHigh = 1'b1;
        pwmLow = 1'b1;
        tick(2);
        check(16'({high_gate_out, low_gate_out}), 16'h3);
        endOfTest();
    end
endmodule : test_smart_gate_drive_sequencer
